// File: link_sync_input_control.sv
// Purpose: selects and conditions the link sync request, sequences CGS and ILAS starts,
//          and turns SYSREF edges into a timing reference event
// Assumes: all pin inputs are asynchronous to clock and are synchronised here
// Notes: a release must stay stable RELEASE_HOLD_CYC cycles before ILAS is started
`include "link_sync_params.svh"

module link_sync_input_control (
  input wire logic clock,
  input wire logic rst,
  input wire logic mode_64b66b,
  input wire logic sync_select,
  input wire logic single_ended_sync_request_n,
  input wire logic differential_marker_input_n,
  input wire logic sysref,
  output link_sync_pkg::link_phase_t phase,
  output link_sync_pkg::link_events_t events
);
  // same time scope as the bench modules around it
  timeunit 1ns;
  timeprecision 1ps;
  import link_sync_pkg::*;

  localparam int HOLD_CYC = `RELEASE_HOLD_CYC;

  // two-stage synchronisers; first stage read only by second stage
  logic [4:0] meta_r, meta_nxt;
  logic [4:0] sync_r, sync_nxt;
  logic sysref_d_r, sysref_d_nxt;
  logic req_d_r, req_d_nxt;

  always_comb begin
    meta_nxt = {mode_64b66b, sync_select, single_ended_sync_request_n,
                differential_marker_input_n, sysref};
    sync_nxt = meta_r;
    sysref_d_nxt = sync_r[0];
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      meta_r <= `SYNC_STAGES_RST; // 8b/10b, so no false step out of idle after reset
      sync_r <= `SYNC_STAGES_RST;
      sysref_d_r <= `SYSREF_ALIGN_RST;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
      sysref_d_r <= sysref_d_nxt;
    end
  end

  logic is_64b, sel_diff, req_active;
  always_comb begin
    is_64b = sync_r[4];
    sel_diff = sync_r[3];
    // mux picks one source only, other pin is never looked at
    req_active = sel_diff ? ~sync_r[1] : ~sync_r[2];
  end

  // link phase sequencer
  link_phase_t phase_r, phase_nxt;
  logic [7:0] hold_r, hold_nxt;
  link_events_t ev_r, ev_nxt;

  always_comb begin
    phase_nxt = phase_r;
    hold_nxt = hold_r;
    req_d_nxt = req_active;
    ev_nxt = '0;
    ev_nxt.sysref_event = sync_r[0] & ~sysref_d_r;
    // in 64b/66b a falling request edge only syncs the mixers
    ev_nxt.nco_sync = is_64b & req_active & ~req_d_r;
    if (is_64b) begin
      phase_nxt = PH_DATA;
      hold_nxt = 8'h00;
    end else begin
      case (phase_r)
        PH_IDLE, PH_DATA: begin
          if (req_active) begin
            phase_nxt = PH_CGS;
            ev_nxt.cgs_start = 1'b1;
          end
        end
        PH_CGS: begin
          // glitch filter: release must hold before ILAS begins
          if (req_active) begin
            hold_nxt = 8'h00;
          end else if (hold_r >= 8'(HOLD_CYC - 1)) begin
            phase_nxt = PH_ILAS;
            ev_nxt.ilas_start = 1'b1;
            hold_nxt = 8'h00;
          end else begin
            hold_nxt = hold_r + 8'h01;
          end
        end
        PH_ILAS: begin
          if (req_active) begin
            phase_nxt = PH_CGS;
            ev_nxt.cgs_start = 1'b1;
          end else begin
            phase_nxt = PH_DATA;
          end
        end
        default: phase_nxt = PH_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      phase_r <= PH_IDLE;
      hold_r <= 8'h00;
      ev_r <= '0;
      req_d_r <= 1'b0;
    end else begin
      phase_r <= phase_nxt;
      hold_r <= hold_nxt;
      ev_r <= ev_nxt;
      req_d_r <= req_d_nxt;
    end
  end

  assign phase = phase_r;
  assign events = ev_r;

  // assertions
  property p_cgs_on_request;
    @(posedge clock) disable iff (rst)
      (!is_64b && req_active && phase_r == PH_IDLE) |=> (phase_r == PH_CGS && ev_r.cgs_start);
  endproperty
  a_cgs_on_request: assert property (p_cgs_on_request) else $error("cgs not started");

  sequence s_release_held;
    (!req_active && !is_64b && phase_r == PH_CGS) [*2];
  endsequence
  property p_ilas_after_release;
    @(posedge clock) disable iff (rst)
      s_release_held |=> (phase_r == PH_ILAS && ev_r.ilas_start);
  endproperty
  a_ilas_after_release: assert property (p_ilas_after_release) else $error("ilas late");

  property p_no_ilas_while_low;
    @(posedge clock) disable iff (rst) req_active |=> !ev_r.ilas_start;
  endproperty
  a_no_ilas_while_low: assert property (p_no_ilas_while_low) else $error("ilas during req");

  property p_64b_no_cgs;
    @(posedge clock) disable iff (rst) is_64b |=> !ev_r.cgs_start;
  endproperty
  a_64b_no_cgs: assert property (p_64b_no_cgs) else $error("cgs in 64b66b");

  property p_select_zero_source;
    @(posedge clock) disable iff (rst)
      (!sync_r[3] && !sync_r[2] && !is_64b && (phase_r == PH_IDLE || phase_r == PH_DATA))
      |=> ev_r.cgs_start;
  endproperty
  a_select_zero_source: assert property (p_select_zero_source) else $error("wrong se source");

  property p_select_one_source;
    @(posedge clock) disable iff (rst)
      (sync_r[3] && !sync_r[1] && !is_64b && (phase_r == PH_IDLE || phase_r == PH_DATA))
      |=> ev_r.cgs_start;
  endproperty
  a_select_one_source: assert property (p_select_one_source) else $error("wrong diff source");

  property p_diff_active_low;
    @(posedge clock) disable iff (rst)
      (sync_r[3] && !sync_r[1] && !is_64b && phase_r == PH_DATA) |=> ev_r.cgs_start;
  endproperty
  a_diff_active_low: assert property (p_diff_active_low) else $error("diff polarity");

  property p_unselected_ignored;
    @(posedge clock) disable iff (rst)
      (!sync_r[3] && sync_r[2] && !is_64b && phase_r == PH_DATA) |=> !ev_r.cgs_start;
  endproperty
  a_unselected_ignored: assert property (p_unselected_ignored) else $error("unselected used");

  property p_sysref_edge;
    @(posedge clock) disable iff (rst) $rose(sync_r[0]) |=> ev_r.sysref_event;
  endproperty
  a_sysref_edge: assert property (p_sysref_edge) else $error("sysref edge missed");

  // a sysref event only ever follows a low-to-high step of the synced pin
  property p_sysref_step;
    @(posedge clock) disable iff (rst)
      ev_r.sysref_event |-> ($past(sync_r[0]) && !$past(sync_r[0], 2));
  endproperty
  a_sysref_step: assert property (p_sysref_step) else $error("sysref no edge");

  // 64b/66b holds the phase in data, the request never restarts the link
  property p_64b_stays_data;
    @(posedge clock) disable iff (rst) is_64b |=> (phase_r == PH_DATA);
  endproperty
  a_64b_stays_data: assert property (p_64b_stays_data) else $error("phase moved in 64b66b");

  // mixer sync pulses belong to 64b/66b only
  property p_nco_only_64b;
    @(posedge clock) disable iff (rst) !is_64b |=> !ev_r.nco_sync;
  endproperty
  a_nco_only_64b: assert property (p_nco_only_64b) else $error("nco sync in 8b10b");

  // code group sync lasts as long as the receiver keeps its request low
  property p_cgs_held;
    @(posedge clock) disable iff (rst)
      (!is_64b && req_active && phase_r == PH_CGS) |=> (phase_r == PH_CGS && !ev_r.ilas_start);
  endproperty
  a_cgs_held: assert property (p_cgs_held) else $error("cgs left early");

  // a start pulse always comes with the phase it starts
  property p_cgs_pulse_phase;
    @(posedge clock) disable iff (rst) ev_r.cgs_start |-> (phase_r == PH_CGS);
  endproperty
  a_cgs_pulse_phase: assert property (p_cgs_pulse_phase) else $error("cgs pulse off phase");

  // lane alignment lasts one cycle and hands over to data while released
  sequence s_ilas_entered;
    ev_r.ilas_start && phase_r == PH_ILAS;
  endsequence
  sequence s_still_released;
    !req_active && !is_64b;
  endsequence
  property p_ilas_to_data;
    @(posedge clock) disable iff (rst)
      (s_ilas_entered ##0 s_still_released) |=> (phase_r == PH_DATA);
  endproperty
  a_ilas_to_data: assert property (p_ilas_to_data) else $error("no data after ilas");
endmodule

// File: link_sync_params.svh
// Purpose: timing and reset constants for the link sync input control block
// Assumes: 40 MHz system clock
// Notes: definitions only
`ifndef LINK_SYNC_PARAMS_SVH
`define LINK_SYNC_PARAMS_SVH
`define CLOCK_PERIOD_NS 25
`define RELEASE_HOLD_NS 50
`define RELEASE_HOLD_CYC ((`RELEASE_HOLD_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define SYSREF_ALIGN_RST 1'b0
// synchroniser reset: 8b/10b, select one, both requests released, sysref low
`define SYNC_STAGES_RST 5'h0E
`endif

// File: link_sync_pkg.sv
// Purpose: types shared by the link sync input control block
// Assumes: nothing beyond the params header
// Notes: link phase enumeration and grouped status outputs
package link_sync_pkg;
  timeunit 1ns;
  timeprecision 1ps;
  typedef enum logic [1:0] {
    PH_IDLE,
    PH_CGS,
    PH_ILAS,
    PH_DATA
  } link_phase_t;

  typedef struct packed {
    logic cgs_start;
    logic ilas_start;
    logic nco_sync;
    logic sysref_event;
  } link_events_t;
endpackage

// File: rx_model.sv
// Purpose: far-end receiver that requests and releases link sync
// Assumes: active-low request, released high outside requests
// Notes: registered so it moves only after a clock edge
module rx_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic want,
  output logic sync_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // low while sync wanted, high once code groups are in step
  always_ff @(posedge clock) begin
    sync_n <= rst ? 1'b1 : !want;
  end
endmodule

// File: link_sync_input_control_bench.sv
// Purpose: self-checking bench for the link sync input control block
// Assumes: 40 MHz clock, inputs driven by nba at the rising edge
// Notes: the unselected pin carries lfsr noise throughout
module link_sync_input_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import link_sync_pkg::*;
  logic clock, rst, mode, sel, want, sysref, rx_n, se_n, diff_n;
  logic [31:0] seed = 32'hD6F2111D;
  link_phase_t phase;
  link_events_t events, acc;
  int err_count, n_tests;
  link_sync_input_control link_sync_input_control_i (.clock(clock), .rst(rst),
    .mode_64b66b(mode), .sync_select(sel), .single_ended_sync_request_n(se_n),
    .differential_marker_input_n(diff_n), .sysref(sysref), .phase(phase), .events(events));
  rx_model rx_model_i (.clock(clock), .rst(rst), .want(want), .sync_n(rx_n));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task conclude;
    if (err_count == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input logic [3:0] got, input logic [3:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("Error %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // or together every event pulse over n cycles, sampled mid-cycle
  task watch(input int n);
    acc = '0;
    repeat (n) begin
      @(negedge clock);
      acc = acc | events;
    end
  endtask
  initial begin
    clock = 0;
    forever #12.5 clock = !clock;
  end
  // noise on the unselected pin must never reach the link logic
  always @(posedge clock) begin
    seed <= lfsr(seed);
    se_n <= sel ? seed[0] : rx_n;
    diff_n <= sel ? rx_n : seed[0];
  end
  initial begin
    #(2000 * 25);
    err_count++;
    conclude;
  end
  initial begin
    {rst, mode, sel, want, sysref} = 5'h10;
    repeat (10) @(posedge clock);
    rst <= 0;
    for (int s = 0; s < 2; s++) begin
      @(posedge clock) sel <= s[0];
      repeat (12) @(posedge clock);
      want <= 1;
      watch(8);
      chk(acc, 4'h8);
      chk(4'(phase), 4'(PH_CGS));
      @(posedge clock) want <= 0;
      watch(10);
      chk(acc, 4'h4);
      chk(4'(phase), 4'(PH_DATA));
      watch(30);
      chk(acc, 4'h0);
    end
    @(posedge clock) mode <= 1;
    repeat (8) @(posedge clock);
    want <= 1;
    watch(8);
    chk(acc, 4'h2);
    chk(4'(phase), 4'(PH_DATA));
    @(posedge clock) sysref <= 1;
    watch(8);
    chk(acc, 4'h1);
    conclude;
  end
endmodule
